// *** hdl/urx_pkg.sv ***
// Purpose: shared constants and types for the serial receive block
// Assumes: one clock domain, 8 data bits, receive fifo of four entries
// Notes: parity codes and fifo depth are fixed here, not parameters
package urx_pkg;

   // ****************************************
   // frame and fifo sizing
   // ****************************************
   localparam int unsigned URX_DATA_W = 8;
   localparam int unsigned URX_DIV_W = 16;
   localparam int unsigned URX_FIFO_DEPTH = 4;
   localparam int unsigned URX_PTR_W = 2;
   localparam int unsigned URX_CNT_W = 3;
   localparam int unsigned URX_BITCNT_W = 4;
   // data bits, then optional extra/parity bit, then stop bit
   localparam logic [3:0] URX_BITS_PLAIN = 4'h9;
   localparam logic [3:0] URX_BITS_EXTRA = 4'hA;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [URX_DATA_W-1:0] URX_DATA_RST = 8'h00;
   localparam logic [URX_DIV_W-1:0] URX_DIV_RST = 16'h0000;

   // ****************************************
   // parity type select codes
   // ****************************************
   localparam logic [1:0] URX_PAR_ODD = 2'h0;
   localparam logic [1:0] URX_PAR_EVEN = 2'h1;
   localparam logic [1:0] URX_PAR_MARK = 2'h2;
   localparam logic [1:0] URX_PAR_SPACE = 2'h3;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      URX_ST_IDLE = 2'b00,
      URX_ST_START = 2'b01,
      URX_ST_BITS = 2'b10
   } urx_state_e;

   typedef struct packed {
      logic rx_enable;
      logic extra_bit_enable;
      logic parity_enable;
      logic [1:0] parity_type_select;
      logic multiproc_enable;
      logic [URX_DIV_W-1:0] baud_div;
   } urx_cfg_s;

   typedef struct packed {
      logic [URX_DATA_W-1:0] data;
      logic extra;
   } urx_entry_s;

endpackage

// *** hdl/urx_rx.sv ***
// Purpose: serial receiver with fifo, parity check and address filtering
// Assumes: i_rxd is synchronous to i_core_clk; baud_div >= 2
// Notes: all control and status bits are plain ports, no register bus
//
// Summary of operation
// - extra bit on, parity off: flag shows oldest byte's extra bit.
// - extra bit off: flag shows oldest byte's received stop bit.
// - parity on: check received parity bit against selected parity type.
// - parity mismatch sets sticky parity error flag until software clears.
// - parity on disables extra bit; that position carries parity.
// - multiproc on: receive event only when the stored flag bit is one (extra bit, or stop bit as above).
`timescale 1ns/1ps
`default_nettype none
module urx_rx
   import urx_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_rxd,
   input wire urx_pkg::urx_cfg_s i_cfg,
   input wire logic i_receive_flag_clr,
   input wire logic i_buf_read,
   input wire logic i_parity_error_clr,
   output logic [urx_pkg::URX_DATA_W-1:0] o_serial_buffer,
   output logic o_received_extra_bit,
   output logic o_receive_flag,
   output logic o_parity_error_flag,
   output logic o_fifo_full
);
   import urx_pkg::*;

   // ****************************************
   // helpers
   // ****************************************
   // expected parity bit for a byte under the chosen type
   function automatic logic exp_parity(input logic [URX_DATA_W-1:0] d,
                                       input logic [1:0] sel);
      logic r;
      r = 1'b0;
      unique case (sel)
         URX_PAR_ODD: r = ~(^d);
         URX_PAR_EVEN: r = ^d;
         URX_PAR_MARK: r = 1'b1;
         URX_PAR_SPACE: r = 1'b0;
      endcase
      return r;
   endfunction

   // ****************************************
   // declarations
   // ****************************************
   urx_state_e state_q;
   logic [URX_DIV_W-1:0] baud_cnt_q;
   logic [URX_BITCNT_W-1:0] bit_idx_q;
   logic [URX_BITCNT_W-1:0] bits_tot_q;
   logic [URX_DATA_W-1:0] shift_q;
   logic xbit_q;
   logic rxd_q;
   logic xbe_frame_q;
   logic pe_frame_q;
   urx_entry_s mem_q [URX_FIFO_DEPTH];
   logic [URX_PTR_W-1:0] wr_ptr_q;
   logic [URX_PTR_W-1:0] rd_ptr_q;
   logic [URX_CNT_W-1:0] count_q;
   logic tick;
   logic frame_done;
   logic stop_bit;
   logic stored_extra;
   logic par_bad;
   logic push;
   logic pop;
   urx_entry_s new_entry;

   assign tick = (baud_cnt_q == URX_DIV_RST);
   assign frame_done = (state_q == URX_ST_BITS) && tick
                       && (bit_idx_q == bits_tot_q - 4'h1);
   assign stop_bit = i_rxd;

   // ****************************************
   // frame decode at the stop bit
   // ****************************************
   // parity mode wins: the extra position is then the parity bit
   always_comb
   begin
      if (xbe_frame_q && !pe_frame_q)
         stored_extra = xbit_q;
      else
         stored_extra = stop_bit;
      par_bad = pe_frame_q
                && (xbit_q != exp_parity(shift_q,
                                         i_cfg.parity_type_select));
      new_entry.data = shift_q;
      new_entry.extra = stored_extra;
   end

   // address filter: plain data bytes are dropped when multiproc is on
   assign push = frame_done
                 && !(i_cfg.multiproc_enable && !stored_extra)
                 && (count_q != URX_CNT_W'(URX_FIFO_DEPTH));
   assign pop = i_buf_read && (count_q != '0);

   // ****************************************
   // line sampler
   // ****************************************
   // previous line level, for falling-edge start detection
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
         rxd_q <= 1'b1;
      else if (i_ce)
         rxd_q <= i_rxd;
   end

   // start at half a bit, then one sample per bit period
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         state_q <= URX_ST_IDLE;
         baud_cnt_q <= URX_DIV_RST;
         bit_idx_q <= '0;
         bits_tot_q <= URX_BITS_PLAIN;
         xbe_frame_q <= 1'b0;
         pe_frame_q <= 1'b0;
      end
      else if (i_ce)
      begin
         unique case (state_q)
            URX_ST_IDLE:
            begin
               if (i_cfg.rx_enable && rxd_q && !i_rxd)
               begin
                  state_q <= URX_ST_START;
                  baud_cnt_q <= i_cfg.baud_div >> 1;
                  // extra-bit and parity enables are frozen per frame; parity type and multiproc are read live
                  xbe_frame_q <= i_cfg.extra_bit_enable;
                  pe_frame_q <= i_cfg.parity_enable;
                  bits_tot_q <= (i_cfg.extra_bit_enable
                                 || i_cfg.parity_enable)
                                ? URX_BITS_EXTRA : URX_BITS_PLAIN;
               end
            end
            URX_ST_START:
            begin
               if (tick)
               begin
                  baud_cnt_q <= i_cfg.baud_div - 16'h0001;
                  bit_idx_q <= '0;
                  // a glitch shorter than half a bit is not a start
                  state_q <= i_rxd ? URX_ST_IDLE : URX_ST_BITS;
               end
               else
                  baud_cnt_q <= baud_cnt_q - 16'h0001;
            end
            URX_ST_BITS:
            begin
               if (frame_done)
                  state_q <= URX_ST_IDLE;
               else if (tick)
               begin
                  baud_cnt_q <= i_cfg.baud_div - 16'h0001;
                  bit_idx_q <= bit_idx_q + 4'h1;
               end
               else
                  baud_cnt_q <= baud_cnt_q - 16'h0001;
            end
            default: state_q <= URX_ST_IDLE;
         endcase
      end
   end

   // data bits arrive lsb first; the ninth position is the extra bit
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         shift_q <= URX_DATA_RST;
         xbit_q <= 1'b0;
      end
      else if (i_ce && state_q == URX_ST_BITS && tick)
      begin
         if (bit_idx_q < URX_BITCNT_W'(URX_DATA_W))
            shift_q <= {i_rxd, shift_q[URX_DATA_W-1:1]};
         else if (bit_idx_q == URX_BITCNT_W'(URX_DATA_W) && !frame_done)
            xbit_q <= i_rxd;
      end
   end

   // ****************************************
   // receive fifo
   // ****************************************
   // a byte arriving while full is lost; o_fifo_full warns software
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else if (i_ce)
      begin
         if (push)
            wr_ptr_q <= wr_ptr_q + 2'h1;
         if (pop)
            rd_ptr_q <= rd_ptr_q + 2'h1;
         count_q <= count_q + URX_CNT_W'(push) - URX_CNT_W'(pop);
      end
   end

   // storage has no reset; contents are only read when counted valid
   always_ff @(posedge i_core_clk)
   begin
      if (i_ce && push)
         mem_q[wr_ptr_q] <= new_entry;
   end

   // ****************************************
   // registered outputs
   // ****************************************
   // head of fifo copied out; lags a push or pop by one cycle
   // an empty fifo keeps the last byte: unwritten storage never shows
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         o_serial_buffer <= URX_DATA_RST;
         o_received_extra_bit <= 1'b0;
         o_fifo_full <= 1'b0;
      end
      else if (i_ce)
      begin
         if (count_q != '0)
         begin
            o_serial_buffer <= mem_q[rd_ptr_q].data;
            o_received_extra_bit <= mem_q[rd_ptr_q].extra;
         end
         o_fifo_full <= (count_q == URX_CNT_W'(URX_FIFO_DEPTH));
      end
   end

   // receive flag: a new byte or leftover bytes after a read win over clear
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
         o_receive_flag <= 1'b0;
      else if (i_ce)
      begin
         if (push)
            o_receive_flag <= 1'b1;
         else if (pop && count_q > URX_CNT_W'(1))
            o_receive_flag <= 1'b1;
         else if (i_receive_flag_clr)
            o_receive_flag <= 1'b0;
      end
   end

   // sticky parity error; a new error in the clear cycle is kept
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
         o_parity_error_flag <= 1'b0;
      else if (i_ce)
      begin
         if (frame_done && par_bad)
            o_parity_error_flag <= 1'b1;
         else if (i_parity_error_clr)
            o_parity_error_flag <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// *** sim/urx_rx_sva.sv ***
// Purpose: port checks for the receive block
// Assumes: one clock, i_ce high
// Notes: quiet_q counts idle line cycles
`timescale 1ns/1ps
`default_nettype none
module urx_rx_sva
   import urx_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_rxd,
   input wire urx_pkg::urx_cfg_s i_cfg,
   input wire logic i_receive_flag_clr,
   input wire logic i_buf_read,
   input wire logic i_parity_error_clr,
   input wire logic [urx_pkg::URX_DATA_W-1:0] o_serial_buffer,
   input wire logic o_received_extra_bit,
   input wire logic o_receive_flag,
   input wire logic o_parity_error_flag,
   input wire logic o_fifo_full
);
   logic [23:0] quiet_q;
   logic quiet;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   // idle beyond a whole frame, so no push can be pending
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst || !i_rxd)
         quiet_q <= 24'h000000;
      else if (quiet_q != 24'hFFFFFF)
         quiet_q <= quiet_q + 24'h000001;
   end
   assign quiet = quiet_q > {4'h0, i_cfg.baud_div, 4'h0};
   a_reset_clears: assert property (disable iff (1'b0)
      i_sys_rst && i_ce |=> !o_receive_flag && !o_fifo_full
      && !o_parity_error_flag && o_serial_buffer == 8'h00)
      else $error("outputs not cleared by reset");
   a_perr_sticky: assert property (
      o_parity_error_flag && !i_parity_error_clr && i_ce
      |=> o_parity_error_flag) else $error("parity error dropped");
   a_perr_clear: assert property (
      i_parity_error_clr && quiet && i_ce |=> !o_parity_error_flag)
      else $error("parity error not cleared");
   a_perr_cause: assert property (
      $rose(o_parity_error_flag) |-> $past(i_cfg.parity_enable))
      else $error("parity error without parity");
   a_flag_clear: assert property (
      i_receive_flag_clr && !i_buf_read && quiet && i_ce
      |=> !o_receive_flag) else $error("receive flag not cleared");
   a_flag_hold: assert property (
      o_receive_flag && !i_receive_flag_clr && i_ce |=> o_receive_flag)
      else $error("receive flag dropped");
   a_refill_flag: assert property (
      o_fifo_full && i_buf_read && i_ce |=> o_receive_flag)
      else $error("flag not set with bytes left");
   a_full_hold: assert property (
      o_fifo_full && !i_buf_read && !$past(i_buf_read) && i_ce
      |=> o_fifo_full && $stable(o_serial_buffer)
      && $stable(o_received_extra_bit))
      else $error("full fifo changed without a read");
endmodule
bind urx_rx urx_rx_sva u_urx_rx_sva (.i_core_clk(i_core_clk),
   .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_rxd(i_rxd), .i_cfg(i_cfg),
   .i_receive_flag_clr(i_receive_flag_clr), .i_buf_read(i_buf_read),
   .i_parity_error_clr(i_parity_error_clr),
   .o_serial_buffer(o_serial_buffer),
   .o_received_extra_bit(o_received_extra_bit),
   .o_receive_flag(o_receive_flag),
   .o_parity_error_flag(o_parity_error_flag), .o_fifo_full(o_fifo_full));
`default_nettype wire

// *** sim/urx_line_model.sv ***
// Purpose: remote serial transmitter
// Assumes: line idles high
// Notes: frames are sent by task call
`timescale 1ns/1ps
`default_nettype none
module urx_line_model
(
   input wire logic i_core_clk,
   output logic o_txd
);
   initial o_txd = 1'b1;
   // start, lsb first data, optional ninth bit, stop, then idle
   task automatic send_frame(input logic [7:0] d, input logic has9,
      input logic b9, input logic st, input logic [15:0] div);
      logic [10:0] f;
      f = has9 ? {st, b9, d, 1'b0} : {1'b1, st, d, 1'b0};
      for (int i = 0; i < (has9 ? 11 : 10); i++)
      begin
         @(posedge i_core_clk);
         o_txd <= f[i];
         repeat (int'(div) - 1) @(posedge i_core_clk);
      end
      @(posedge i_core_clk);
      o_txd <= 1'b1;
   endtask
endmodule
`default_nettype wire

// *** sim/urx_rx_tb.sv ***
// Purpose: self-checking bench for the receive block
// Assumes: bit time of eight clocks
// Notes: waits out a long idle after every frame
`timescale 1ns/1ps
`default_nettype none
module urx_rx_tb;
   import urx_pkg::*;
   localparam logic [15:0] DIV = 16'h0008;
   logic clk, rst, ce, rxd, clr, rd, pclr, ox, fl, pe, full;
   logic [7:0] ob;
   urx_cfg_s cfg;
   int mismatches = 0, checks = 0, cyc = 0;
   urx_rx u_urx_rx (.i_core_clk(clk), .i_sys_rst(rst), .i_ce(ce),
      .i_rxd(rxd), .i_cfg(cfg), .i_receive_flag_clr(clr),
      .i_buf_read(rd), .i_parity_error_clr(pclr),
      .o_serial_buffer(ob), .o_received_extra_bit(ox),
      .o_receive_flag(fl), .o_parity_error_flag(pe), .o_fifo_full(full));
   urx_line_model u_urx_line_model (.i_core_clk(clk), .o_txd(rxd));
   // ***********************
   // clock, timeout, report
   // ***********************
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // a hang ends the run as a mismatch
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         mismatches++;
         final_report();
      end
   end
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // ***********************
   // shared steps
   // ***********************
   task automatic frame(input logic [7:0] d, input logic h, b, s);
      u_urx_line_model.send_frame(d, h, b, s, DIV);
      repeat (140) @(posedge clk);
   endtask
   // software drain step: check flag and buffer, clear flag, read buffer
   task automatic take(input logic [7:0] d, input logic x);
      check({8'h00, fl}, 9'h001);
      check({ox, ob}, {x, d});
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // ***********************
   // scenarios
   // ***********************
   task automatic t_multiproc;
      cfg.extra_bit_enable <= 1'b1;
      cfg.multiproc_enable <= 1'b1;
      frame(8'h5A, 1'b1, 1'b0, 1'b1);
      check({8'h00, fl}, 9'h000);
      frame(8'hA3, 1'b1, 1'b1, 1'b1);
      check({ox, ob}, 9'h1A3);
      cfg.multiproc_enable <= 1'b0; // address matched
      frame(8'h3C, 1'b1, 1'b0, 1'b1);
      take(8'hA3, 1'b1);
      take(8'h3C, 1'b0);
      check({8'h00, fl}, 9'h000);
      cfg.multiproc_enable <= 1'b1; // message over
      frame(8'h44, 1'b1, 1'b0, 1'b1);
      check({8'h00, fl}, 9'h000);
      // a second address owned by this slave is taken as well
      frame(8'hA7, 1'b1, 1'b1, 1'b1);
      take(8'hA7, 1'b1);
   endtask
   task automatic t_stop;
      cfg.extra_bit_enable <= 1'b0;
      cfg.multiproc_enable <= 1'b0;
      frame(8'h81, 1'b0, 1'b0, 1'b1);
      frame(8'h7E, 1'b0, 1'b0, 1'b0);
      // clock enable low: clear and read must both be ignored
      ce <= 1'b0;
      clr <= 1'b1;
      rd <= 1'b1;
      @(posedge clk);
      ce <= 1'b1;
      clr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
      take(8'h81, 1'b1);
      take(8'h7E, 1'b0);
   endtask
   // every parity type: good, bad, good again, then clear
   task automatic t_parity;
      logic p;
      cfg.extra_bit_enable <= 1'b1;
      cfg.parity_enable <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         cfg.parity_type_select <= 2'(i);
         p = (i == 0) ? 1'b1 : (i == 2);
         frame(8'h35, 1'b1, p, 1'b1);
         check({8'h00, pe}, 9'h000);
         frame(8'h35, 1'b1, ~p, 1'b1);
         check({8'h00, pe}, 9'h001);
         frame(8'h35, 1'b1, p, 1'b1);
         check({8'h00, pe}, 9'h001);
         pclr <= 1'b1;
         @(posedge clk);
         pclr <= 1'b0;
         @(posedge clk);
         check({8'h00, pe}, 9'h000);
         for (int k = 0; k < 3; k++)
            take(8'h35, 1'b1); // stop bit shown
      end
      cfg.parity_enable <= 1'b0;
   endtask
   task automatic t_full;
      cfg.extra_bit_enable <= 1'b0;
      for (int k = 0; k < 5; k++)
         frame(8'h10 + 8'(k), 1'b0, 1'b0, 1'b1);
      check({8'h00, full}, 9'h001);
      for (int k = 0; k < 4; k++)
         take(8'h10 + 8'(k), 1'b1);
      check({7'h00, full, fl}, 9'h000);
   endtask
   // reset, then each scenario in turn
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      clr = 1'b0;
      rd = 1'b0;
      pclr = 1'b0;
      cfg = '0;
      cfg.rx_enable = 1'b1;
      cfg.baud_div = DIV;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      check({ox, ob}, 9'h000);
      check({6'h00, fl, pe, full}, 9'h000);
      t_multiproc();
      t_stop();
      t_parity();
      t_full();
      final_report();
   end
endmodule
`default_nettype wire
